// ==== design/sar_ctrl_pkg.sv ====
`default_nettype none
package sar_ctrl_pkg;
  localparam int RES_BITS = 12;
  localparam int CLK_MHZ = 125;
  localparam int WAIT_NS = 10000;
  localparam int WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 12;
  localparam logic [RES_BITS-1:0] TOP_BIT = 12'h800;

  typedef struct packed {
    logic sw_start;
    logic trig;
    logic single_conversion_select;
    logic wake;
  } ctrl_in_t;

  typedef struct packed {
    logic done;
    logic status;
    logic busy;
    logic ready;
  } stat_out_t;

  typedef enum logic [3:0] {
    ST_WAIT = 4'h1,
    ST_IDLE = 4'h2,
    ST_CONV = 4'h4,
    ST_HOLD = 4'h8
  } state_t;
endpackage
`default_nettype wire

// ==== design/sar_approx.sv ====
`default_nettype none
module sar_approx #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic go,
  input wire logic cmp_hi,
  output logic [W-1:0] dac_code,
  output logic fin
);
  logic [W-1:0] code_r, code_nxt;
  logic [W-1:0] bit_r, bit_nxt;
  logic fin_r, fin_nxt;

  always_comb begin
    code_nxt = code_r;
    bit_nxt = bit_r;
    fin_nxt = 1'b0;
    if (go) begin
      code_nxt = {1'b1, {(W-1){1'b0}}};
      bit_nxt = {1'b1, {(W-1){1'b0}}};
    end else if (bit_r != '0) begin
      // keep or drop current trial bit, then try the next lower one
      code_nxt = cmp_hi ? code_r : (code_r & ~bit_r);
      bit_nxt = bit_r >> 1;
      if (bit_r[0]) begin
        fin_nxt = 1'b1;
      end else begin
        code_nxt = code_nxt | (bit_r >> 1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_r <= '0;
      bit_r <= '0;
      fin_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      bit_r <= bit_nxt;
      fin_r <= fin_nxt;
    end
  end

  assign dac_code = code_r;
  assign fin = fin_r;

  msb_first_a: assert property (@(posedge clk) disable iff (sys_rst)
    go |=> bit_r[W-1] && dac_code[W-1])
    else $error("trial does not start at msb");
  conv_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    fin |-> $past(go, W + 1))
    else $error("conversion length wrong");
  fin_due_a: assert property (@(posedge clk) disable iff (sys_rst)
    (bit_r == {{(W-1){1'b0}}, 1'b1} && !go) |=> fin)
    else $error("lsb trial did not finish");
endmodule
`default_nettype wire

// ==== design/sar_adc_conversion_control.sv ====
`default_nettype none
module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter int WAIT_CYCLES = sar_ctrl_pkg::WAIT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control side
  input wire sar_ctrl_pkg::ctrl_in_t ctrl,
  input wire logic result_rd,
  // analog core
  input wire logic cmp_hi,
  output logic [sar_ctrl_pkg::RES_BITS-1:0] dac_code,
  // result and status
  output logic [sar_ctrl_pkg::RES_BITS-1:0] result,
  output sar_ctrl_pkg::stat_out_t stat
);
  import sar_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [RES_BITS-1:0] res_r, res_nxt;
  logic done_r, done_nxt;
  logic stat_r, stat_nxt;
  logic trig_d_r, trig_d_nxt;
  logic go, fin, start_req, trig_edge;

  assign trig_edge = ctrl.trig & ~trig_d_r;
  // one conversion per trigger edge; continuous retriggers itself
  assign start_req = ctrl.sw_start | trig_edge;

  sar_approx #(.W(RES_BITS)) u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(go),
    .cmp_hi(cmp_hi),
    .dac_code(dac_code),
    .fin(fin)
  );

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    res_nxt = res_r;
    done_nxt = done_r;
    stat_nxt = stat_r;
    trig_d_nxt = ctrl.trig;
    go = 1'b0;
    // read clears flags unless a new result lands this cycle
    if (result_rd) begin
      done_nxt = 1'b0;
      stat_nxt = 1'b0;
    end
    case (st_r)
      ST_WAIT: begin
        if (cnt_r >= CNT_W'(WAIT_CYCLES - 1)) begin
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_IDLE: begin
        if (start_req) begin
          go = 1'b1;
          st_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        // start requests ignored here
        if (fin) begin
          res_nxt = dac_code;
          done_nxt = 1'b1;
          stat_nxt = 1'b1;
          if (!ctrl.single_conversion_select) begin
            go = 1'b1;
          end else begin
            st_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // wake aborts any conversion and restarts the ready wait
    if (ctrl.wake) begin
      st_nxt = ST_WAIT;
      cnt_nxt = '0;
      go = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_WAIT;
      cnt_r <= '0;
      res_r <= '0;
      done_r <= 1'b0;
      stat_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
      stat_r <= stat_nxt;
      trig_d_r <= trig_d_nxt;
    end
  end

  assign result = res_r;

  // status outputs decode the registered state
  always_comb begin
    stat.done = done_r;
    stat.status = stat_r;
    stat.busy = (st_r == ST_CONV);
    stat.ready = (st_r != ST_WAIT);
  end

  // ---------------------------------------------------------------
  // checks: ready wait
  // ---------------------------------------------------------------
  no_early_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_WAIT) |-> !go)
    else $error("conversion began before ready wait");
  wait_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(st_r == ST_IDLE) && $past(st_r) == ST_WAIT)
      |-> $past(cnt_r) == CNT_W'(WAIT_CYCLES - 1))
    else $error("ready wait length wrong");
  wake_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl.wake |=> (st_r == ST_WAIT) && !stat.ready)
    else $error("wake did not restart ready wait");
  wake_go_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl.wake |-> !go)
    else $error("conversion began during wake");
  cnt_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl.wake |=> cnt_r == '0)
    else $error("ready wait counter not cleared");
  cnt_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_WAIT) |-> cnt_r <= CNT_W'(WAIT_CYCLES - 1))
    else $error("ready wait counter overran");
  ready_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stat.ready && !ctrl.wake) |=> stat.ready)
    else $error("ready dropped without wake");
  wait_refuse_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_WAIT && ctrl.sw_start) |=> !stat.busy)
    else $error("start taken during ready wait");

  // ---------------------------------------------------------------
  // checks: starts and modes
  // ---------------------------------------------------------------
  start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && ctrl.sw_start && !ctrl.wake) |=> stat.busy)
    else $error("start not taken");
  trig_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && trig_edge && !ctrl.wake) |=> stat.busy)
    else $error("trigger edge not taken");
  go_busy_a: assert property (@(posedge clk) disable iff (sys_rst)
    (go && !ctrl.wake) |=> stat.busy)
    else $error("started conversion not busy");
  idle_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && !start_req) |-> !go)
    else $error("conversion began without request");
  busy_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && !fin) |-> !go)
    else $error("restart during conversion");
  trig_lost_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && trig_edge && !fin) |-> !go)
    else $error("trigger taken during conversion");
  trig_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_IDLE && ctrl.trig && trig_d_r && !ctrl.sw_start) |-> !go)
    else $error("held trigger restarted");
  single_go_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && ctrl.single_conversion_select) |-> !go)
    else $error("single mode restarted itself");
  single_conversion_select_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && fin && ctrl.single_conversion_select
      && !ctrl.wake) |=> st_r == ST_IDLE)
    else $error("single mode did not stop");
  cont_run_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && fin && !ctrl.single_conversion_select
      && !ctrl.wake) |=> st_r == ST_CONV)
    else $error("continuous mode stopped");
  cont_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && fin && !ctrl.single_conversion_select
      && !ctrl.wake) |=> stat.done)
    else $error("continuous result not requested");

  // ---------------------------------------------------------------
  // checks: completion
  // ---------------------------------------------------------------
  done_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r == ST_CONV && fin && !ctrl.wake) |=> stat.done && stat.status
      && result == $past(dac_code))
    else $error("completion not flagged");
  done_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stat.done && !result_rd && !ctrl.wake) |=> stat.done)
    else $error("done dropped before read");
  done_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (result_rd && !(st_r == ST_CONV && fin)) |=> !stat.done)
    else $error("done not cleared by read");
  status_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stat.status && !result_rd) |=> stat.status)
    else $error("status dropped before read");
  status_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
    (result_rd && !(st_r == ST_CONV && fin)) |=> !stat.status)
    else $error("status not cleared by read");
  done_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(stat.done) |-> $past(st_r == ST_CONV && fin))
    else $error("done raised without completion");
  res_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(st_r == ST_CONV && fin) |=> $stable(result))
    else $error("result changed outside completion");
endmodule
`default_nettype wire

// ==== verification/sar_cmp_model.sv ====
`default_nettype none
module sar_cmp_model (
  // analog side
  input wire logic [11:0] vin,
  input wire logic [11:0] dac_code,
  output logic cmp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // keep the trial bit while the input is at or above the code
  assign cmp_hi = vin >= dac_code;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
module tb_top;
  import sar_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, result_rd = 0, cmp_hi;
  ctrl_in_t ctrl = '0;
  logic [11:0] vin = 12'h000, dac_code, result;
  stat_out_t stat;
  logic [11:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0;
  always #4 clk = ~clk; // system rate; core clock limit rests with its source
  sar_adc_conversion_control #(.WAIT_CYCLES(8)) i_sar_adc_conversion_control (
    .clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .result_rd(result_rd),
    .cmp_hi(cmp_hi), .dac_code(dac_code), .result(result), .stat(stat));
  sar_cmp_model i_sar_cmp_model (
    .vin(vin), .dac_code(dac_code), .cmp_hi(cmp_hi));
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // reader standing in for the dma: one read per completion
  always @(negedge clk) begin
    if (result_rd) begin
      chk("done_clr", stat.done, 0);
      chk("status_clr", stat.status, 0);
      result_rd = 0;
    end else if (stat.done === 1'b1) begin
      chk("status", stat.status, 1);
      chk("result", result, exp_q.size() ? exp_q.pop_front() : 'x);
      result_rd = 1;
    end
  end
  task automatic conv(input logic [11:0] v, input int n, input bit hw);
    vin = v;
    repeat (n) exp_q.push_back(v);
    if (hw) ctrl.trig = 1;
    else ctrl.sw_start = 1;
    cyc(1);
    ctrl.sw_start = 0;
    ctrl.trig = 0;
    chk("busy", stat.busy, 1);
    chk("msb_trial", dac_code, TOP_BIT);
    ctrl.sw_start = 1;
    cyc(1);
    ctrl.sw_start = 0;
    ctrl.trig = 1;
    cyc(1);
    ctrl.trig = 0;
  endtask
  task automatic drain;
    int k = 0;
    while ((exp_q.size() || stat.done !== 1'b0) && k < 300) begin
      cyc(1);
      k++;
    end
    chk("drained", k < 300, 1);
  endtask
  initial begin
    void'($urandom(32'h98b6));
    cyc(6);
    sys_rst = 0;
    ctrl.sw_start = 1;
    cyc(1);
    ctrl.sw_start = 0;
    chk("early_busy", stat.busy, 0);
    chk("early_ready", stat.ready, 0);
    cyc(9);
    chk("ready", stat.ready, 1);
    $display("test ready wait done");
    ctrl.single_conversion_select = 1;
    for (int i = 0; i < 6; i++) begin
      conv(i == 0 ? 12'hfff : i == 1 ? 12'h000 : 12'($urandom), 1, i[0]);
      drain();
      cyc(20);
      chk("idle", stat.busy, 0);
    end
    $display("test single done");
    // a trigger held high starts exactly one conversion
    vin = 12'($urandom);
    exp_q.push_back(vin);
    ctrl.trig = 1;
    cyc(30);
    ctrl.trig = 0;
    drain();
    chk("held_trig", stat.busy, 0);
    $display("test held trigger done");
    ctrl.single_conversion_select = 0;
    conv(12'h5a3, 3, 0); // software start; conv still pulses trig high for one cycle
    drain();
    ctrl.wake = 1;
    cyc(1);
    ctrl.wake = 0;
    ctrl.sw_start = 1;
    chk("wake_ready", stat.ready, 0);
    cyc(1);
    ctrl.sw_start = 0;
    chk("wake_refuse", stat.busy, 0);
    cyc(30);
    chk("aborted", stat.busy, 0);
    chk("rewake_ready", stat.ready, 1);
    $display("test continuous done");
    summarize();
  end
  initial begin
    #50us;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
